// ===== smawu_defines.svh
// Purpose: register map, field positions, reset values and counts of the stop mode wakeup block
// Assumes: 32-bit apb words, one register per aligned word, byte address = index * 4
// Notes: definitions only
`ifndef SMAWU_DEFINES_SVH
`define SMAWU_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register indices (byte address is four times the index)
`define SMAWU_IDX_PORT_A 6'h00
`define SMAWU_IDX_KBD_STATUS 6'h01
`define SMAWU_IDX_KBD_ENABLES 6'h02
`define SMAWU_IDX_OPTION_TWO 6'h1E
`define SMAWU_IDX_OPTION_ONE 6'h1F

////////////////////////////////////////////////////////////////////////////////
// field positions
`define SMAWU_PA_WAKE_LATCH 6
`define SMAWU_KS_FLAG 3
`define SMAWU_KS_ACK 2
`define SMAWU_KS_MASK 1
`define SMAWU_KE_WAKE_IRQ_EN 6
`define SMAWU_O2_IRQ_PULLUP_OFF 7
`define SMAWU_O2_IRQ_PIN_EN 6
`define SMAWU_O2_OSC_RUN_IN_STOP 1
`define SMAWU_O2_RESET_PIN_EN 0
`define SMAWU_O1_PERIOD_SEL 7
`define SMAWU_O1_LVI_TRIP 3

////////////////////////////////////////////////////////////////////////////////
// reset values and masks
`define SMAWU_OPT_ONE_RESET 8'h00
`define SMAWU_OPT_TWO_RESET 8'h00
`define SMAWU_KBD_EN_RESET 7'h00
`define SMAWU_OPT_TWO_USED 8'hC3
`define SMAWU_OPT_ONE_RST_BITS 8'hF7

////////////////////////////////////////////////////////////////////////////////
// wakeup periods in cycles of the selected wakeup clock
`define SMAWU_SHORT_PERIOD 14'h0200
`define SMAWU_LONG_PERIOD_M1 14'h3FFF
`define SMAWU_CNT_W 14

`endif

// ===== smawu_osc_model.sv
// Purpose: wakeup and main oscillator levels seen by the wakeup block
// Assumes: each level toggles every HALF bus cycles while enabled
// Notes: a stopped oscillator rests low and restarts its phase
`timescale 1ns/1ns
module smawu_osc_model #(
  parameter int HALF = 2
) (
  input wire logic i_clk,
  input wire logic i_run_rc,
  input wire logic i_run_osc,
  output logic o_rc,
  output logic o_osc
);
  int rc_n = 0;
  int osc_n = 0;
  always @(posedge i_clk) begin
    rc_n <= i_run_rc ? rc_n + 1 : 0;
    osc_n <= i_run_osc ? osc_n + 1 : 0;
  end
  assign o_rc = ((rc_n / HALF) % 2) == 1;
  assign o_osc = ((osc_n / HALF) % 2) == 1;
endmodule : smawu_osc_model

// ===== smawu_pkg.sv
// Purpose: shared types of the stop mode wakeup block
// Assumes: smawu_defines.svh for the numbers
// Notes: none
package smawu_pkg;

  typedef enum logic {SMAWU_GEN_OFF, SMAWU_GEN_RUN} smawu_gen_state_t;

  // option bits handed to the rest of the chip
  typedef struct packed {
    logic reset_pin_enable;
    logic irq_pin_enable;
    logic irq_pullup_off;
    logic main_osc_enable;
    logic wake_rc_osc_enable;
    logic watchdog_short_period;
    logic [7:0] option_one;
  } smawu_sys_cfg_t;

  function automatic logic [7:0] smawu_byte_addr(input logic [5:0] idx);
    smawu_byte_addr = {idx, 2'b00};
  endfunction : smawu_byte_addr

endpackage : smawu_pkg

// ===== smawu_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: asynchronous active low reset
// Notes: the first stage feeds only the second
`timescale 1ns/1ns
module smawu_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_d,
  output logic o_q
);
  logic meta_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : smawu_sync

// ===== smawu_top.sv
// Purpose: stop mode auto wakeup with its keypad flag, mask, acknowledge and option registers
// Assumes: apb slave, zero wait states; i_rst_b is also low during every power-on reset
// Notes: wakeup clocks arrive as levels and are synchronised before counting
`timescale 1ns/1ns
`include "smawu_defines.svh"
module smawu_top
  import smawu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_por_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_stop_mode,
  input wire logic i_wake_rc_osc,
  input wire logic i_osc_clock_x4,
  input wire logic i_keypad_request,
  output logic o_keypad_irq,
  output smawu_sys_cfg_t o_sys_cfg
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic key_pend_q;
  logic wake_latch_q;
  logic mask_q;
  logic [6:0] kbd_en_q;
  logic [7:0] opt_one_q;
  logic lvi_trip_q;
  logic [7:0] opt_two_q;
  logic reset_pin_en_q;
  logic opt_one_done_q;
  logic opt_two_done_q;
  logic [31:0] prdata_q;
  logic irq_q;
  smawu_sys_cfg_t sys_cfg_q;

  logic rc_sync;
  logic osc_sync;
  logic wake_request;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire sel_port_a = (i_paddr == smawu_byte_addr(`SMAWU_IDX_PORT_A));
  wire sel_kbd_status = (i_paddr == smawu_byte_addr(`SMAWU_IDX_KBD_STATUS));
  wire sel_kbd_en = (i_paddr == smawu_byte_addr(`SMAWU_IDX_KBD_ENABLES));
  wire sel_opt_two = (i_paddr == smawu_byte_addr(`SMAWU_IDX_OPTION_TWO));
  wire sel_opt_one = (i_paddr == smawu_byte_addr(`SMAWU_IDX_OPTION_ONE));
  wire mapped = sel_port_a | sel_kbd_status | sel_kbd_en | sel_opt_two | sel_opt_one;

  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire wr = access & i_pwrite & mapped;

  wire wr_kbd_status = wr & sel_kbd_status;
  wire wr_kbd_en = wr & sel_kbd_en;
  // a refused second write still completes on the bus without error
  wire wr_opt_one = wr & sel_opt_one & ~opt_one_done_q;
  wire wr_opt_two = wr & sel_opt_two & ~opt_two_done_q;

  wire ack = wr_kbd_status & i_pwdata[`SMAWU_KS_ACK];

  //////////////////////////////////////////////////////////////////////////////
  // derived fields

  wire wake_irq_en = kbd_en_q[`SMAWU_KE_WAKE_IRQ_EN];
  wire osc_run_in_stop = opt_two_q[`SMAWU_O2_OSC_RUN_IN_STOP];
  wire period_select = opt_one_q[`SMAWU_O1_PERIOD_SEL];
  wire keypad_flag = key_pend_q | wake_latch_q;
  wire irq_d = keypad_flag & ~mask_q;

  wire [7:0] port_a_rd = {1'b0, wake_latch_q, 6'h00};
  // upper nibble and the acknowledge bit always read zero
  wire [7:0] kbd_status_rd = {4'h0, keypad_flag, 1'b0, mask_q, 1'b0};
  wire [7:0] kbd_en_rd = {1'b0, kbd_en_q};
  wire [7:0] opt_two_rd = {opt_two_q[7:1], reset_pin_en_q};
  wire [7:0] opt_one_rd = {opt_one_q[7:4], lvi_trip_q, opt_one_q[2:0]};

  wire [7:0] rd_byte = sel_port_a ? port_a_rd :
                       sel_kbd_status ? kbd_status_rd :
                       sel_kbd_en ? kbd_en_rd :
                       sel_opt_two ? opt_two_rd :
                       sel_opt_one ? opt_one_rd : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // wakeup clock synchronisers and period counter

  smawu_sync u_rc_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d(i_wake_rc_osc),
    .o_q(rc_sync)
  );

  smawu_sync u_osc_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d(i_osc_clock_x4),
    .o_q(osc_sync)
  );

  smawu_wake_gen u_gen (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_stop_mode(i_stop_mode),
    .i_enable(wake_irq_en),
    .i_use_osc(osc_run_in_stop),
    .i_short_period(period_select),
    .i_rc_level(rc_sync),
    .i_osc_level(osc_sync),
    .o_wake_request(wake_request)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pending requests: a new request beats a simultaneous acknowledge

  logic wake_latch_d;
  logic key_pend_d;

  wire wake_set = wake_request & wake_irq_en;

  always_comb begin
    wake_latch_d = wake_latch_q;
    if (wake_set) begin
      wake_latch_d = 1'b1;
    end else if (ack) begin
      wake_latch_d = 1'b0;
    end
  end

  // keypad pin requests are not gated by the enables, only the wake source is
  always_comb begin
    key_pend_d = key_pend_q;
    if (i_keypad_request) begin
      key_pend_d = 1'b1;
    end else if (ack) begin
      key_pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_latch_q <= 1'b0;
      key_pend_q <= 1'b0;
    end else begin
      wake_latch_q <= wake_latch_d;
      key_pend_q <= key_pend_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // keypad mask and enables

  logic mask_d;
  logic [6:0] kbd_en_d;

  always_comb begin
    mask_d = mask_q;
    if (wr_kbd_status) begin
      mask_d = i_pwdata[`SMAWU_KS_MASK];
    end
  end

  always_comb begin
    kbd_en_d = kbd_en_q;
    if (wr_kbd_en) begin
      kbd_en_d = i_pwdata[6:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_q <= 1'b0;
      kbd_en_q <= `SMAWU_KBD_EN_RESET;
    end else begin
      mask_q <= mask_d;
      kbd_en_q <= kbd_en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write-once option registers, cleared by any reset except option two bit 0 and option one bit 3

  logic [7:0] opt_one_d;
  logic [7:0] opt_two_d;
  logic opt_one_done_d;
  logic opt_two_done_d;

  // a refused write leaves both the value and the done flag as they are
  always_comb begin
    opt_one_d = opt_one_q;
    opt_one_done_d = opt_one_done_q;
    if (wr_opt_one) begin
      opt_one_d = i_pwdata[7:0] & `SMAWU_OPT_ONE_RST_BITS;
      opt_one_done_d = 1'b1;
    end
  end

  // bits 5..2 are not stored and bit 0 lives in the power-on domain
  always_comb begin
    opt_two_d = opt_two_q;
    opt_two_done_d = opt_two_done_q;
    if (wr_opt_two) begin
      opt_two_d = i_pwdata[7:0] & `SMAWU_OPT_TWO_USED & 8'hFE;
      opt_two_done_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_one_q <= `SMAWU_OPT_ONE_RESET;
      opt_one_done_q <= 1'b0;
    end else begin
      opt_one_q <= opt_one_d;
      opt_one_done_q <= opt_one_done_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_two_q <= `SMAWU_OPT_TWO_RESET;
      opt_two_done_q <= 1'b0;
    end else begin
      opt_two_q <= opt_two_d;
      opt_two_done_q <= opt_two_done_d;
    end
  end

  // these survive ordinary resets; only power-on clears them
  logic reset_pin_en_d;
  logic lvi_trip_d;

  always_comb begin
    reset_pin_en_d = reset_pin_en_q;
    if (wr_opt_two) begin
      reset_pin_en_d = i_pwdata[`SMAWU_O2_RESET_PIN_EN];
    end
  end

  always_comb begin
    lvi_trip_d = lvi_trip_q;
    if (wr_opt_one) begin
      lvi_trip_d = i_pwdata[`SMAWU_O1_LVI_TRIP];
    end
  end

  always_ff @(posedge i_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      reset_pin_en_q <= 1'b0;
    end else begin
      reset_pin_en_q <= reset_pin_en_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      lvi_trip_q <= 1'b0;
    end else begin
      lvi_trip_q <= lvi_trip_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs toward the core and the rest of the chip

  wire main_osc_en = ~i_stop_mode | osc_run_in_stop;
  wire rc_osc_en = i_stop_mode & wake_irq_en & ~osc_run_in_stop;

  smawu_sys_cfg_t sys_cfg_d;

  always_comb begin
    sys_cfg_d.reset_pin_enable = reset_pin_en_q;
    sys_cfg_d.irq_pin_enable = opt_two_q[`SMAWU_O2_IRQ_PIN_EN];
    sys_cfg_d.irq_pullup_off = opt_two_q[`SMAWU_O2_IRQ_PULLUP_OFF];
    sys_cfg_d.main_osc_enable = main_osc_en;
    sys_cfg_d.wake_rc_osc_enable = rc_osc_en;
    // the watchdog is idle in stop, so the bit is only its choice outside
    sys_cfg_d.watchdog_short_period = period_select & ~i_stop_mode;
    sys_cfg_d.option_one = opt_one_rd;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_cfg_q <= '0;
    end else begin
      sys_cfg_q <= sys_cfg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb read data: captured in setup so the access phase needs no wait

  logic [31:0] prdata_d;

  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_keypad_irq = irq_q;
  assign o_sys_cfg = sys_cfg_q;

endmodule : smawu_top

// ===== smawu_top_sva.sv
// Purpose: bus, flag and option checks on the ports of smawu_top
// Assumes: one clock domain, asynchronous active low reset
// Notes: mask state is tracked from bus writes to the status register
`timescale 1ns/1ns
module smawu_top_sva
  import smawu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_stop_mode,
  input wire logic i_keypad_request,
  input wire logic o_keypad_irq,
  input wire smawu_sys_cfg_t o_sys_cfg
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic mask_q;
  wire acc = i_psel && i_penable;
  wire hit = i_paddr inside {8'h00, 8'h04, 8'h08, 8'h78, 8'h7C};
  wire rd_acc = acc && !i_pwrite;
  wire kw = acc && i_pwrite && i_paddr == 8'h04;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) mask_q <= 1'h0;
    else if (kw) mask_q <= i_pwdata[1];
  end
  // a wake latch may still land while stopped, so only quiet acks count
  sequence ack_wr_s;
    kw && i_pwdata[2] && !i_keypad_request && !i_stop_mode && !$past(i_stop_mode);
  endsequence
  unmapped_err_a: assert property (acc && !hit |-> o_pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && hit |-> !o_pslverr)
    else $error("error on mapped access");
  status_bits_a: assert property (rd_acc && i_paddr == 8'h04 |->
    o_prdata[7:4] == 4'h0 && !o_prdata[2] && !o_prdata[0])
    else $error("status fixed bits not zero");
  port_a_bits_a: assert property (rd_acc && i_paddr == 8'h00 |->
    (o_prdata & 32'hFFFFFFBF) == 32'h0)
    else $error("port a shows more than the latch");
  mask_block_a: assert property (mask_q && $past(mask_q) |-> !$rose(o_keypad_irq))
    else $error("irq rose while masked");
  ack_clear_a: assert property (ack_wr_s |=> ##1 !o_keypad_irq)
    else $error("irq still high after ack");
  wdog_stop_a: assert property (i_stop_mode |=> !o_sys_cfg.watchdog_short_period)
    else $error("watchdog select passed in stop");
  main_osc_a: assert property (i_rst_b && !i_stop_mode |=> o_sys_cfg.main_osc_enable)
    else $error("main clock off outside stop");
  rc_idle_a: assert property (!i_stop_mode |=> !o_sys_cfg.wake_rc_osc_enable)
    else $error("wake oscillator on outside stop");
endmodule : smawu_top_sva

bind smawu_top smawu_top_sva u_sva (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_stop_mode(i_stop_mode), .i_keypad_request(i_keypad_request),
  .o_keypad_irq(o_keypad_irq), .o_sys_cfg(o_sys_cfg)
);

// ===== smawu_wake_gen.sv
// Purpose: wakeup period counter, runs only in stop mode
// Assumes: wakeup clock levels already synchronised to i_clk
// Notes: counts rising edges of the selected wakeup clock
`timescale 1ns/1ns
`include "smawu_defines.svh"
module smawu_wake_gen
  import smawu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_stop_mode,
  input wire logic i_enable,
  input wire logic i_use_osc,
  input wire logic i_short_period,
  input wire logic i_rc_level,
  input wire logic i_osc_level,
  output logic o_wake_request
);
  smawu_gen_state_t state_q;
  smawu_gen_state_t state_d;
  logic [`SMAWU_CNT_W-1:0] count_q;
  logic sel_prev_q;

  wire sel_level = i_use_osc ? i_osc_level : i_rc_level;
  wire tick = sel_level & ~sel_prev_q;
  wire run = i_stop_mode & i_enable;
  wire [`SMAWU_CNT_W-1:0] last = i_short_period ?
    (`SMAWU_SHORT_PERIOD - 14'h0001) : `SMAWU_LONG_PERIOD_M1;
  wire at_last = (count_q == last);

  always_comb begin
    case (state_q)
      SMAWU_GEN_OFF: state_d = run ? SMAWU_GEN_RUN : SMAWU_GEN_OFF;
      SMAWU_GEN_RUN: state_d = run ? SMAWU_GEN_RUN : SMAWU_GEN_OFF;
      default: state_d = SMAWU_GEN_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= SMAWU_GEN_OFF;
      count_q <= '0;
      sel_prev_q <= 1'b0;
      o_wake_request <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_prev_q <= sel_level;
      o_wake_request <= 1'b0;
      if (state_q != SMAWU_GEN_RUN || !run) begin
        count_q <= '0;
      end else if (tick) begin
        count_q <= at_last ? '0 : count_q + 14'h0001;
        o_wake_request <= at_last;
      end
    end
  end
endmodule : smawu_wake_gen

// ===== stop_mode_auto_wakeup_test.sv
// Purpose: self-checking bench for smawu_top
// Assumes: oscillator model gives one rising edge per four bus cycles
// Notes: wake latency is exact for the rc clock, with slack only for the free oscillator phase
`timescale 1ns/1ns
module stop_mode_auto_wakeup_test;
  import smawu_pkg::*;
  localparam int LIM = 80000;
  logic i_clk = 1'h0;
  logic i_rst_b = 1'h0;
  logic i_por_b = 1'h0;
  logic i_psel = 1'h0;
  logic i_penable = 1'h0;
  logic i_pwrite = 1'h0;
  logic i_stop_mode = 1'h0;
  logic i_keypad_request = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, rdata;
  logic o_pready, o_pslverr, o_keypad_irq, serr, rc, osc;
  smawu_sys_cfg_t o_sys_cfg;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int c;
  always #10 i_clk = ~i_clk;
  smawu_top u_smawu_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_stop_mode(i_stop_mode), .i_wake_rc_osc(rc), .i_osc_clock_x4(osc),
    .i_keypad_request(i_keypad_request), .o_keypad_irq(o_keypad_irq), .o_sys_cfg(o_sys_cfg));
  smawu_osc_model u_smawu_osc_model (.i_clk(i_clk), .i_run_rc(o_sys_cfg.wake_rc_osc_enable),
    .i_run_osc(o_sys_cfg.main_osc_enable), .o_rc(rc), .o_osc(osc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      fails++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_n(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD %0t wake after %0d cycles", $time, got);
    end
  endtask : chk_n
  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'h1;
    do @(posedge i_clk); while (o_pready !== 1'h1 && cyc < LIM);
    rdata = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00);
    chk(rdata, exp);
  endtask : rdchk
  task automatic rst(input logic por);
    i_rst_b <= 1'h0;
    i_por_b <= ~por;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'h1;
    i_por_b <= 1'h1;
    @(posedge i_clk);
  endtask : rst
  task automatic hold_stop(input logic s, input int n);
    i_stop_mode <= s;
    repeat (n) @(posedge i_clk);
  endtask : hold_stop
  task automatic wait_irq(input int lim);
    c = 0;
    while (o_keypad_irq !== 1'h1 && c < lim) begin
      @(posedge i_clk);
      c++;
    end
  endtask : wait_irq
  task automatic kp_pulse;
    i_keypad_request <= 1'h1;
    @(posedge i_clk);
    i_keypad_request <= 1'h0;
    repeat (4) @(posedge i_clk);
  endtask : kp_pulse
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] m [5] = '{8'h00, 8'h04, 8'h08, 8'h78, 8'h7C};
    foreach (m[k]) rdchk(m[k], 32'h0);
    rdchk(8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    wr(8'h00, 8'hFF);
    rdchk(8'h00, 32'h0);
    wr(8'h04, 8'hF1);
    rdchk(8'h04, 32'h0);
    wr(8'h08, 8'hFF);
    rdchk(8'h08, 32'h7F);
  endtask : t_regs
  task automatic t_keypad;
    kp_pulse();
    chk({31'h0, o_keypad_irq}, 32'h1);
    rdchk(8'h04, 32'h08);
    wr(8'h04, 8'h06);
    @(posedge i_clk);
    chk({31'h0, o_keypad_irq}, 32'h0);
    rdchk(8'h04, 32'h02);
    kp_pulse();
    chk({31'h0, o_keypad_irq}, 32'h0);
    rdchk(8'h04, 32'h0A);
    wr(8'h04, 8'h00);
    wait_irq(8);
    chk({31'h0, o_keypad_irq}, 32'h1);
    wr(8'h04, 8'h06);
  endtask : t_keypad
  task automatic t_once;
    wr(8'h78, 8'hFF);
    wr(8'h78, 8'h00);
    rdchk(8'h78, 32'hC3);
    wr(8'h7C, 8'h88);
    wr(8'h7C, 8'h00);
    rdchk(8'h7C, 32'h88);
    chk({18'h0, o_sys_cfg}, {18'h0, 6'h3D, 8'h88});
    hold_stop(1'h1, 3);
    chk({18'h0, o_sys_cfg}, {18'h0, 6'h3C, 8'h88});
    hold_stop(1'h0, 3);
    rst(1'h0);
    rdchk(8'h78, 32'h01);
    rdchk(8'h7C, 32'h08);
    rdchk(8'h04, 32'h00);
    rdchk(8'h08, 32'h00);
    rst(1'h1);
    rdchk(8'h78, 32'h00);
    rdchk(8'h7C, 32'h00);
  endtask : t_once
  task automatic t_short;
    wr(8'h7C, 8'h80);
    wr(8'h78, 8'h00);
    hold_stop(1'h1, 2200);
    chk({31'h0, o_keypad_irq}, 32'h0);
    hold_stop(1'h0, 4);
    wr(8'h08, 8'h40);
    hold_stop(1'h1, 1200);
    chk({31'h0, o_sys_cfg.main_osc_enable}, 32'h0);
    hold_stop(1'h0, 20);
    i_stop_mode <= 1'h1;
    wait_irq(4000);
    chk_n(c, 4 * 512 + 5, 4 * 512 + 5);
    rdchk(8'h00, 32'h40);
    wr(8'h04, 8'h04);
    rdchk(8'h00, 32'h00);
    hold_stop(1'h0, 4);
  endtask : t_short
  task automatic t_long;
    rst(1'h0);
    wr(8'h7C, 8'h00);
    wr(8'h78, 8'h02);
    wr(8'h08, 8'h40);
    i_stop_mode <= 1'h1;
    wait_irq(70000);
    chk_n(c, 4 * 16384 + 1, 4 * 16384 + 4);
    hold_stop(1'h0, 2);
    rst(1'h0);
    rdchk(8'h00, 32'h00);
    rdchk(8'h04, 32'h00);
  endtask : t_long
  initial begin
    rst(1'h1);
    t_regs();
    t_keypad();
    t_once();
    t_short();
    t_long();
    results();
  end
endmodule : stop_mode_auto_wakeup_test
